// ---- hw/mmee_pkg.sv ----
package mmee_pkg;

  // ----------------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------------
  localparam logic [31:0] MMEE_LEGACY_LO = 32'h000A_0000;
  localparam logic [31:0] MMEE_LEGACY_HI = 32'h000B_FFFF;
  localparam logic [31:0] MMEE_EXT_SIZE = 32'h000E_0000;
  localparam logic [31:0] MMEE_HIGH_SIZE = 32'h0010_0000;
  localparam logic [31:0] MMEE_BASE_RST = 32'h0003_0000;
  localparam logic [31:0] MMEE_ENTRY_OFS = 32'h0000_8000;
  localparam logic [31:0] MMEE_ALIGN_MASK = 32'h0000_7FFF;

  // ----------------------------------------------------------------------
  // save area layout
  // ----------------------------------------------------------------------
  localparam logic [15:0] MMEE_OFS_AREA = 16'h7E00;
  localparam logic [15:0] MMEE_OFS_BASE = 16'h7EF8;
  localparam logic [15:0] MMEE_OFS_REV = 16'h7EFC;
  localparam logic [15:0] MMEE_OFS_IO = 16'h7F00;
  localparam logic [15:0] MMEE_OFS_CORE = 16'h7FC8;
  localparam logic [15:0] MMEE_IO_RESTART = 16'h00FF;
  localparam logic [15:0] MMEE_IO_NONE = 16'h0000;
  localparam int MMEE_HALT_BIT = 16;
  localparam int MMEE_REV_RELOC_BIT = 17;
  localparam int MMEE_REV_IORST_BIT = 16;
  localparam logic [4:0] MMEE_CORE_WORDS = 5'h0E;
  localparam logic [4:0] MMEE_SAVE_LAST = 5'h10;

  // ----------------------------------------------------------------------
  // entry state
  // ----------------------------------------------------------------------
  localparam logic [15:0] MMEE_CS_SEL = 16'h3000;
  localparam logic [31:0] MMEE_EIP = 32'h0000_8000;
  localparam logic [31:0] MMEE_EFLAGS = 32'h0000_0002;
  localparam logic [31:0] MMEE_CR4 = 32'h0000_0000;
  localparam logic [31:0] MMEE_CR0_CLR = 32'h8000_000D;
  localparam logic [31:0] MMEE_SEG_LIMIT = 32'hFFFF_FFFF;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SAVE = 3'h1,
    ST_ENTER = 3'h2,
    ST_ACTIVE = 3'h3,
    ST_RESTORE = 3'h4,
    ST_CHECK = 3'h5,
    ST_EXIT = 3'h6,
    ST_SHUTDOWN = 3'h7
  } mmee_state_t;

  function automatic logic [6:0] mmee_widx(input logic [15:0] ofs);
    logic [15:0] diff;
    diff = ofs - MMEE_OFS_AREA;
    return diff[8:2];
  endfunction

endpackage

// ---- hw/mmee_mem_if.sv ----
`timescale 1ns/1ps
interface mmee_mem_if;
  logic [6:0] addr;
  logic wr;
  logic rd;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport ctl (output addr, output wr, output rd, output wdata, input rdata);
  modport mem (input addr, input wr, input rd, input wdata, output rdata);
endinterface

// ---- hw/mmee_save_ram.sv ----
`timescale 1ns/1ps
module mmee_save_ram #(
  parameter int AW = 7
) (
  input wire logic i_clk,
  input wire logic i_rst,
  mmee_mem_if.mem m
);
  logic [31:0] mem_q [2**AW];

  always_ff @(posedge i_clk) begin
    if (m.wr) begin
      mem_q[m.addr] <= m.wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      m.rdata <= 32'h0000_0000;
    end else if (m.rd) begin
      m.rdata <= mem_q[m.addr];
    end
  end
endmodule

// ---- hw/mmee_top.sv ----
`timescale 1ns/1ps
module mmee_top
  import mmee_pkg::*;
#(
  parameter logic [15:0] VERSION = 16'h0001 // arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_mgmt_interrupt,
  input wire logic i_nmi,
  input wire logic i_init,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_high,
  input wire logic i_cfg_open,
  input wire logic i_cfg_lock,
  input wire logic [31:0] i_top_of_memory,
  input wire logic [31:0] i_video_base,
  input wire logic i_mem_req,
  input wire logic [31:0] i_mem_addr,
  input wire logic [31:0] i_core_word,
  input wire logic i_halted,
  input wire logic i_a20_mask,
  input wire logic i_resume_instr,
  input wire logic i_iret,
  input wire logic i_fw_req,
  input wire logic i_fw_we,
  input wire logic [15:0] i_fw_ofs,
  input wire logic [31:0] i_fw_wdata,
  output logic [31:0] o_fw_rdata,
  output logic o_fw_rvalid,
  output logic o_acc_valid,
  output logic o_acc_mgmt,
  output logic o_acc_video,
  output logic o_acc_blocked,
  output logic o_acc_cacheable,
  output logic [31:0] o_acc_phys,
  output logic o_cfg_locked,
  output logic [31:0] o_mgmt_base,
  output logic o_mgmt_active,
  output logic [3:0] o_core_idx,
  output logic o_entry_load,
  output logic [15:0] o_entry_cs_sel,
  output logic [31:0] o_entry_cs_base,
  output logic [31:0] o_entry_eip,
  output logic [31:0] o_entry_eflags,
  output logic [31:0] o_entry_cr4,
  output logic [31:0] o_entry_cr0_clr,
  output logic [31:0] o_entry_seg_limit,
  output logic o_entry_size16,
  output logic o_irq_block,
  output logic o_nmi_service,
  output logic o_init_service,
  output logic o_a20_mask,
  output logic o_invalid_opcode,
  output logic o_restore_valid,
  output logic [3:0] o_restore_idx,
  output logic [31:0] o_restore_data,
  output logic o_exit,
  output logic o_rehalt,
  output logic o_io_restart,
  output logic o_shutdown
);

  // ----------------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] smi_s_q;
  logic [2:0] nmi_s_q;
  logic [2:0] init_s_q;
  logic smi_rise;
  logic nmi_rise;
  logic init_rise;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      smi_s_q <= 3'h0;
      nmi_s_q <= 3'h0;
      init_s_q <= 3'h0;
    end else begin
      smi_s_q <= {smi_s_q[1:0], i_mgmt_interrupt};
      nmi_s_q <= {nmi_s_q[1:0], i_nmi};
      init_s_q <= {init_s_q[1:0], i_init};
    end
  end

  assign smi_rise = smi_s_q[1] & ~smi_s_q[2];
  assign nmi_rise = nmi_s_q[1] & ~nmi_s_q[2];
  assign init_rise = init_s_q[1] & ~init_s_q[2];

  // ----------------------------------------------------------------------
  // memory configuration
  // ----------------------------------------------------------------------
  logic high_q;
  logic open_q;
  logic lock_q;
  logic [31:0] tom_q;
  logic [31:0] vwb_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      high_q <= 1'b0;
      open_q <= 1'b0;
      lock_q <= 1'b0;
      tom_q <= 32'h0000_0000;
      vwb_q <= 32'h0000_0000;
    end else if (i_cfg_wr && !lock_q) begin
      high_q <= i_cfg_high;
      open_q <= i_cfg_open;
      lock_q <= i_cfg_lock;
      tom_q <= i_top_of_memory;
      vwb_q <= i_video_base;
    end
  end

  assign o_cfg_locked = lock_q;

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  mmee_state_t state_q;
  logic [4:0] ctr_q;
  logic in_mode;
  logic [31:0] base_q;
  logic [31:0] new_base_q;
  logic [31:0] flag_q;
  logic smi_pend_q;
  logic aligned;

  assign in_mode = (state_q != ST_IDLE);
  assign aligned = ((new_base_q & MMEE_ALIGN_MASK) == 32'h0000_0000);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      ctr_q <= 5'h00;
    end else begin
      ctr_q <= ctr_q + 5'h01;
      unique case (state_q)
        ST_IDLE: begin
          if (smi_rise || smi_pend_q) begin
            state_q <= ST_SAVE;
            ctr_q <= 5'h00;
          end
        end
        ST_SAVE: begin
          if (ctr_q == MMEE_SAVE_LAST) begin
            state_q <= ST_ENTER;
          end
        end
        ST_ENTER: state_q <= ST_ACTIVE;
        ST_ACTIVE: begin
          if (i_resume_instr) begin
            state_q <= ST_RESTORE;
            ctr_q <= 5'h00;
          end
        end
        ST_RESTORE: begin
          if (ctr_q == MMEE_SAVE_LAST) begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: state_q <= aligned ? ST_EXIT : ST_SHUTDOWN;
        ST_EXIT: begin
          state_q <= smi_pend_q ? ST_SAVE : ST_IDLE;
          ctr_q <= 5'h00;
        end
        ST_SHUTDOWN: state_q <= ST_SHUTDOWN;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      smi_pend_q <= 1'b0;
    end else if (smi_rise && in_mode) begin
      smi_pend_q <= 1'b1;
    end else if (state_q == ST_EXIT || state_q == ST_IDLE) begin
      smi_pend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // save area port
  // ----------------------------------------------------------------------
  mmee_mem_if m ();
  logic rvalid_q;
  logic [4:0] rctr_q;
  logic [31:0] rev_word;
  logic [31:0] io_word;

  assign rev_word = {14'h0000, 1'b1, 1'b1, VERSION};
  assign io_word = {15'h0000, i_halted, MMEE_IO_NONE};

  mmee_save_ram #(.AW(7)) u_ram (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .m(m)
  );

  always_comb begin
    m.addr = mmee_widx(i_fw_ofs);
    m.wr = 1'b0;
    m.rd = 1'b0;
    m.wdata = i_fw_wdata;
    if (state_q == ST_ACTIVE) begin
      m.wr = i_fw_req & i_fw_we;
      m.rd = i_fw_req & ~i_fw_we;
    end else if (state_q == ST_SAVE) begin
      m.wr = 1'b1;
      if (ctr_q < MMEE_CORE_WORDS) begin
        m.addr = mmee_widx(MMEE_OFS_CORE) + {3'h0, ctr_q[3:0]};
        m.wdata = i_core_word;
      end else if (ctr_q == MMEE_CORE_WORDS) begin
        m.addr = mmee_widx(MMEE_OFS_BASE);
        m.wdata = base_q;
      end else if (ctr_q == MMEE_SAVE_LAST - 5'h01) begin
        m.addr = mmee_widx(MMEE_OFS_REV);
        m.wdata = rev_word;
      end else begin
        m.addr = mmee_widx(MMEE_OFS_IO);
        m.wdata = io_word;
      end
    end else if (state_q == ST_RESTORE) begin
      m.rd = (ctr_q < MMEE_SAVE_LAST);
      if (ctr_q == 5'h00) begin
        m.addr = mmee_widx(MMEE_OFS_BASE);
      end else if (ctr_q == 5'h01) begin
        m.addr = mmee_widx(MMEE_OFS_IO);
      end else begin
        m.addr = mmee_widx(MMEE_OFS_CORE) + {3'h0, ctr_q[3:0] - 4'h2};
      end
    end
  end

  assign o_core_idx = ctr_q[3:0];
  assign o_fw_rdata = m.rdata;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rvalid_q <= 1'b0;
      rctr_q <= 5'h00;
      o_fw_rvalid <= 1'b0;
    end else begin
      rvalid_q <= (state_q == ST_RESTORE) && m.rd;
      rctr_q <= ctr_q;
      o_fw_rvalid <= (state_q == ST_ACTIVE) && m.rd;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      new_base_q <= MMEE_BASE_RST;
      flag_q <= 32'h0000_0000;
      o_restore_valid <= 1'b0;
      o_restore_idx <= 4'h0;
      o_restore_data <= 32'h0000_0000;
    end else begin
      o_restore_valid <= rvalid_q && (rctr_q > 5'h01);
      o_restore_idx <= rctr_q[3:0] - 4'h2;
      o_restore_data <= m.rdata;
      if (rvalid_q && rctr_q == 5'h00) begin
        new_base_q <= m.rdata;
      end
      if (rvalid_q && rctr_q == 5'h01) begin
        flag_q <= m.rdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // entry and exit
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      base_q <= MMEE_BASE_RST;
    end else if (state_q == ST_EXIT) begin
      base_q <= new_base_q;
    end
  end

  assign o_mgmt_base = base_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_entry_load <= 1'b0;
      o_entry_cs_sel <= 16'h0000;
      o_entry_cs_base <= 32'h0000_0000;
      o_entry_eip <= 32'h0000_0000;
      o_entry_eflags <= 32'h0000_0000;
      o_entry_cr4 <= 32'h0000_0000;
      o_entry_cr0_clr <= 32'h0000_0000;
      o_entry_seg_limit <= 32'h0000_0000;
      o_entry_size16 <= 1'b0;
    end else begin
      o_entry_load <= (state_q == ST_ENTER);
      if (state_q == ST_ENTER) begin
        o_entry_cs_sel <= MMEE_CS_SEL;
        o_entry_cs_base <= base_q;
        o_entry_eip <= MMEE_EIP;
        o_entry_eflags <= MMEE_EFLAGS;
        o_entry_cr4 <= MMEE_CR4;
        o_entry_cr0_clr <= MMEE_CR0_CLR;
        o_entry_seg_limit <= MMEE_SEG_LIMIT;
        o_entry_size16 <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_exit <= 1'b0;
      o_rehalt <= 1'b0;
      o_io_restart <= 1'b0;
      o_shutdown <= 1'b0;
      o_invalid_opcode <= 1'b0;
    end else begin
      o_exit <= (state_q == ST_EXIT);
      o_rehalt <= (state_q == ST_EXIT) && flag_q[MMEE_HALT_BIT];
      o_io_restart <= (state_q == ST_EXIT) &&
                      (flag_q[15:0] == MMEE_IO_RESTART);
      o_shutdown <= (state_q == ST_SHUTDOWN) ||
                    ((state_q == ST_CHECK) && !aligned);
      o_invalid_opcode <= i_resume_instr && (state_q == ST_IDLE);
    end
  end

  // ----------------------------------------------------------------------
  // interrupt gating and address bit 20
  // ----------------------------------------------------------------------
  logic nmi_en_q;
  logic nmi_pend_q;
  logic init_pend_q;
  logic a20_saved_q;
  logic nmi_take;

  assign nmi_take = !in_mode || nmi_en_q || state_q == ST_EXIT;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      nmi_en_q <= 1'b0;
      nmi_pend_q <= 1'b0;
      init_pend_q <= 1'b0;
      o_nmi_service <= 1'b0;
      o_init_service <= 1'b0;
      o_irq_block <= 1'b0;
      o_mgmt_active <= 1'b0;
    end else begin
      o_irq_block <= in_mode && state_q != ST_EXIT;
      o_mgmt_active <= in_mode && state_q != ST_EXIT;
      if (state_q == ST_SAVE) begin
        nmi_en_q <= 1'b0;
      end else if (state_q == ST_ACTIVE && i_iret) begin
        nmi_en_q <= 1'b1;
      end
      o_nmi_service <= nmi_take && (nmi_rise || nmi_pend_q);
      o_init_service <= nmi_take && (init_rise || init_pend_q);
      if (nmi_rise && !nmi_take) begin
        nmi_pend_q <= 1'b1;
      end else if (nmi_take) begin
        nmi_pend_q <= 1'b0;
      end
      if (init_rise && !nmi_take) begin
        init_pend_q <= 1'b1;
      end else if (nmi_take) begin
        init_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      a20_saved_q <= 1'b0;
      o_a20_mask <= 1'b0;
    end else begin
      if (state_q == ST_IDLE) begin
        a20_saved_q <= i_a20_mask;
      end
      if (state_q == ST_EXIT) begin
        o_a20_mask <= a20_saved_q;
      end else if (in_mode) begin
        o_a20_mask <= 1'b0;
      end else begin
        o_a20_mask <= i_a20_mask;
      end
    end
  end

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  logic ok;
  logic leg;
  logic vid;
  logic ext;
  logic hi;
  logic [31:0] vlo;

  assign ok = o_mgmt_active || open_q;
  assign vlo = vwb_q + MMEE_LEGACY_LO;
  assign leg = i_mem_addr >= MMEE_LEGACY_LO && i_mem_addr <= MMEE_LEGACY_HI;
  assign vid = !high_q && i_mem_addr >= vlo &&
               i_mem_addr <= vwb_q + MMEE_LEGACY_HI;
  assign ext = i_mem_addr >= tom_q && i_mem_addr < tom_q + MMEE_EXT_SIZE;
  assign hi = high_q && i_mem_addr >= tom_q &&
              i_mem_addr < tom_q + MMEE_HIGH_SIZE;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_acc_valid <= 1'b0;
      o_acc_mgmt <= 1'b0;
      o_acc_video <= 1'b0;
      o_acc_blocked <= 1'b0;
      o_acc_cacheable <= 1'b0;
      o_acc_phys <= 32'h0000_0000;
    end else begin
      o_acc_valid <= i_mem_req;
      o_acc_mgmt <= 1'b0;
      o_acc_video <= 1'b0;
      o_acc_blocked <= 1'b0;
      o_acc_cacheable <= 1'b0;
      o_acc_phys <= i_mem_addr;
      if (!high_q && leg && ok) begin
        o_acc_mgmt <= 1'b1;
        o_acc_cacheable <= 1'b1;
        o_acc_phys <= tom_q + MMEE_EXT_SIZE + (i_mem_addr - MMEE_LEGACY_LO);
      end else if (leg) begin
        o_acc_video <= 1'b1;
      end else if (vid) begin
        o_acc_video <= 1'b1;
        o_acc_phys <= i_mem_addr - vwb_q;
      end else if (ext || hi) begin
        o_acc_mgmt <= ok;
        o_acc_cacheable <= ok;
        o_acc_blocked <= !ok;
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence seq_exit_steps;
    state_q == ST_EXIT ##1 o_exit && !o_mgmt_active;
  endsequence

  chk_invalid_opcode: assert property (
    i_resume_instr && state_q == ST_IDLE |=> o_invalid_opcode)
    else $error("resume outside mode not refused");
  chk_misalign_shut: assert property (
    state_q == ST_CHECK && !aligned |=> state_q == ST_SHUTDOWN ##1 o_shutdown)
    else $error("misaligned base did not shut down");
  chk_save_first: assert property (
    $rose(o_entry_load) |-> $past(state_q, 2) == ST_SAVE)
    else $error("entry load without prior save");
  chk_entry_cs: assert property (
    $rose(o_entry_load) |-> o_entry_cs_base + MMEE_ENTRY_OFS ==
      o_mgmt_base + o_entry_eip && o_entry_cs_sel == MMEE_CS_SEL)
    else $error("entry point mismatch");
  chk_a20_forced: assert property (
    o_mgmt_active |-> !o_a20_mask)
    else $error("address bit 20 masked in mode");
  chk_smi_latched: assert property (
    state_q == ST_EXIT && smi_pend_q |=> state_q == ST_SAVE)
    else $error("latched interrupt not taken");
  chk_iret_nmi: assert property (
    state_q == ST_ACTIVE && i_iret && nmi_pend_q |=> ##1 o_nmi_service)
    else $error("pending nmi not serviced after iret");
  chk_resume_exit: assert property (
    state_q == ST_CHECK && aligned |=> seq_exit_steps)
    else $error("aligned resume did not exit");
  chk_rehalt: assert property (
    state_q == ST_EXIT && flag_q[MMEE_HALT_BIT] |=> o_rehalt && o_exit)
    else $error("halt flag ignored on resume");
  chk_lock_freeze: assert property (
    lock_q |=> $stable(tom_q) && $stable(high_q) && lock_q)
    else $error("locked config changed");
endmodule

// ---- sim/mmee_sb_model.sv ----
`timescale 1ns/1ps
module mmee_sb_model (
  input wire logic i_clk,
  input wire logic i_raise,
  input wire logic [3:0] i_core_idx,
  output logic o_mgmt_interrupt,
  output logic [31:0] o_core_word
);
  logic [2:0] hold_q = 3'h0;
  // --------------------------------------------------
  // interrupt line and core register words
  // --------------------------------------------------
  assign o_core_word = {28'hC0DE123, i_core_idx};
  assign o_mgmt_interrupt = (hold_q != 3'h0);
  always_ff @(posedge i_clk) begin
    if (i_raise) begin
      hold_q <= 3'h4;
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
    end
  end
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import mmee_pkg::*;
  typedef struct packed {
    logic high; logic open; logic [31:0] addr; logic [2:0] code;
    logic [31:0] phys;
  } mmee_row_t;
  localparam logic [31:0] TOP_OF_MEMORY = 32'h1000_0000;
  localparam logic [31:0] VWB = 32'h2000_0000;
  logic i_clk = 0, i_rst = 1, i_nmi = 0, i_cfg_wr = 0, i_cfg_high = 0;
  logic i_cfg_open = 0, i_cfg_lock = 0, i_mem_req = 0, i_halted = 1;
  logic i_a20_mask = 1, i_resume_instr = 0, i_iret = 0, i_fw_req = 0;
  logic i_fw_we = 0, raise = 0, i_mgmt_interrupt, i_init = 0, o_init_service;
  logic [15:0] i_fw_ofs = 16'h0000;
  logic [31:0] i_mem_addr = 32'h0, i_fw_wdata = 32'h0, i_core_word;
  logic [31:0] o_fw_rdata, o_acc_phys, o_mgmt_base, o_entry_eip;
  logic [31:0] o_entry_eflags, o_entry_cr4, o_entry_seg_limit;
  logic [15:0] o_entry_cs_sel;
  logic [3:0] o_core_idx;
  logic o_acc_mgmt, o_acc_video, o_acc_blocked, o_acc_cacheable;
  logic o_cfg_locked, o_entry_load, o_irq_block, o_nmi_service, o_a20_mask;
  logic o_invalid_opcode, o_exit, o_rehalt, o_io_restart, o_shutdown;
  int checked = 0, fail_count = 0, nmi_cnt = 0;
  mmee_row_t rows [6] = '{
    '{0, 0, 32'h000A_0000, 3'b010, 32'h000A_0000},
    '{0, 0, 32'h200B_FFFF, 3'b010, 32'h000B_FFFF},
    '{0, 0, TOP_OF_MEMORY, 3'b001, TOP_OF_MEMORY},
    '{0, 1, 32'h000B_FFFF, 3'b100, 32'h100F_FFFF},
    '{0, 1, 32'h100D_FFFF, 3'b100, 32'h100D_FFFF},
    '{1, 1, 32'h100F_FFFF, 3'b100, 32'h100F_FFFF}};
  mmee_top DUT (.i_clk, .i_rst, .i_mgmt_interrupt, .i_nmi, .i_init,
    .i_cfg_wr, .i_cfg_high, .i_cfg_open, .i_cfg_lock,
    .i_top_of_memory(TOP_OF_MEMORY), .i_video_base(VWB), .i_mem_req, .i_mem_addr,
    .i_core_word, .i_halted, .i_a20_mask, .i_resume_instr, .i_iret,
    .i_fw_req, .i_fw_we, .i_fw_ofs, .i_fw_wdata, .o_fw_rdata,
    .o_fw_rvalid(), .o_acc_valid(), .o_acc_mgmt, .o_acc_video,
    .o_acc_blocked, .o_acc_cacheable, .o_acc_phys, .o_cfg_locked,
    .o_mgmt_base, .o_mgmt_active(), .o_core_idx, .o_entry_load,
    .o_entry_cs_sel, .o_entry_cs_base(), .o_entry_eip, .o_entry_eflags,
    .o_entry_cr4, .o_entry_cr0_clr(), .o_entry_seg_limit,
    .o_entry_size16(), .o_irq_block, .o_nmi_service, .o_init_service,
    .o_a20_mask, .o_invalid_opcode, .o_restore_valid(), .o_restore_idx(),
    .o_restore_data(), .o_exit, .o_rehalt, .o_io_restart, .o_shutdown);
  mmee_sb_model sb (.i_clk, .i_raise(raise), .i_core_idx(o_core_idx),
    .o_mgmt_interrupt(i_mgmt_interrupt), .o_core_word(i_core_word));
  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_nmi_service === 1'b1) nmi_cnt++;
  // --------------------------------------------------
  // shared tasks
  // --------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wait_hi(ref logic s, input string nm);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 200) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk(nm, 1, s);
    if (n == 200) print_verdict();
  endtask
  task automatic cfg(input logic high, open, lock);
    @(posedge i_clk);
    {i_cfg_high, i_cfg_open, i_cfg_lock, i_cfg_wr} <= {high, open, lock, 1'b1};
    @(posedge i_clk);
    i_cfg_wr <= 1'b0;
  endtask
  task automatic acc(input logic [31:0] a);
    @(posedge i_clk);
    {i_mem_addr, i_mem_req} <= {a, 1'b1};
    @(posedge i_clk);
    i_mem_req <= 1'b0;
    #1;
  endtask
  task automatic fw(input logic we, input logic [15:0] o, input logic [31:0] d);
    @(posedge i_clk);
    {i_fw_req, i_fw_we, i_fw_ofs, i_fw_wdata} <= {1'b1, we, o, d};
    @(posedge i_clk);
    i_fw_req <= 1'b0;
    #1;
  endtask
  // w: 4 resume, 3 nmi, 2 raise, 1 iret, 0 init
  task automatic pulse(input int w);
    @(posedge i_clk);
    {i_resume_instr, i_nmi, raise, i_iret, i_init} <= 5'h01 << w;
    @(posedge i_clk);
    {i_resume_instr, i_nmi, raise, i_iret, i_init} <= 5'h00;
    #1;
  endtask
  // --------------------------------------------------
  // main sequence
  // --------------------------------------------------
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    tick();
    chk("base_rst", 32'h0003_0000, o_mgmt_base);
    pulse(4);
    wait_hi(o_invalid_opcode, "inv_op");
    pulse(0);
    wait_hi(o_init_service, "init_out");
    $display("reset and idle test done");
    foreach (rows[k]) begin
      cfg(rows[k].high, rows[k].open, 1'b0);
      acc(rows[k].addr);
      chk("route", rows[k].code, {o_acc_mgmt, o_acc_video, o_acc_blocked});
      chk("phys", rows[k].phys, o_acc_phys);
      if (rows[k].code[2]) chk("cache", 1, o_acc_cacheable);
    end
    $display("decode test done");
    // close and lock, then a refused reopen
    cfg(1'b0, 1'b0, 1'b1);
    cfg(1'b0, 1'b1, 1'b0);
    acc(32'h000A_0000);
    chk("locked", 1, o_cfg_locked);
    chk("lock_video", 1, o_acc_video);
    $display("lock test done");
    pulse(2);
    wait_hi(o_entry_load, "entry");
    chk("cs", 32'h3000, o_entry_cs_sel);
    chk("eip", 32'h8000, o_entry_eip);
    chk("efl", 32'h2, o_entry_eflags);
    chk("cr4", 32'h0, o_entry_cr4);
    chk("limit", 32'hFFFF_FFFF, o_entry_seg_limit);
    chk("block", 1, o_irq_block);
    chk("a20_in", 0, o_a20_mask);
    fw(1'b0, 16'h7EF8, 32'h0);
    chk("sv_base", 32'h0003_0000, o_fw_rdata);
    fw(1'b0, 16'h7EFC, 32'h0);
    chk("sv_rev", 32'h0003_0001, o_fw_rdata);
    fw(1'b0, 16'h7F00, 32'h0);
    chk("sv_halt", 32'h0001_0000, o_fw_rdata);
    fw(1'b0, 16'h7FC8, 32'h0);
    chk("sv_core", 32'hC0DE_1230, o_fw_rdata);
    pulse(3);
    pulse(2);
    tick(8);
    chk("nmi_held", 0, nmi_cnt);
    pulse(1);
    wait_hi(o_nmi_service, "nmi_iret");
    fw(1'b1, 16'h7EF8, 32'h0004_0000);
    fw(1'b1, 16'h7F00, 32'h0000_00FF);
    pulse(4);
    wait_hi(o_exit, "exit");
    chk("rehalt", 0, o_rehalt);
    chk("io_rst", 1, o_io_restart);
    chk("a20_out", 1, o_a20_mask);
    chk("reloc", 32'h0004_0000, o_mgmt_base);
    $display("entry exit test done");
    wait_hi(o_entry_load, "pend_entry");
    fw(1'b0, 16'h7EF8, 32'h0);
    chk("sv_base2", 32'h0004_0000, o_fw_rdata);
    fw(1'b1, 16'h7EF8, 32'h0004_0100);
    pulse(4);
    wait_hi(o_shutdown, "shutdown");
    $display("shutdown test done");
    print_verdict();
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
endmodule
